// ==== rtl/dscp_device.sv ====
// Purpose: Device end of the serial configuration port
// Assumes: Serial clock comes from the host and stops outside frames
// Notes: Link logic runs on the serial clock, strap outputs on ref_clk_i
`timescale 1ns/100ps
module dscp_device
  import dscp_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic strap_mode_i,
  input wire logic strap_unsigned_i,
  input wire logic power_down_in_i,
  dscp_if.dev link,
  output logic [REG_COUNT-1:0][7:0] regs_o,
  output logic dac_unsigned_o,
  output logic interp_2x_o,
  output logic fullscale_sel_hi_o,
  output logic fullscale_sel_lo_o,
  output logic power_down_o,
  output logic input_buffer_en_o
);

  typedef struct packed {
    dscp_phase_t phase;
    logic [2:0] bit_cnt;
    logic [7:0] sh;
    logic rd;
    logic [1:0] left;
    logic [ADDR_W-1:0] addr;
    logic [7:0] out_sh;
    logic [REG_COUNT-1:0][7:0] regs;
  } dscp_link_t;

  typedef struct packed {
    logic drv;
    logic dout;
  } dscp_drive_t;

  typedef struct packed {
    logic dac_unsigned;
    logic interp_2x;
    logic fs_hi;
    logic fs_lo;
    logic pd;
    logic buf_en;
  } dscp_strap_t;

  function automatic logic [7:0] reg_value(
    input logic [REG_COUNT-1:0][7:0] r, input logic [ADDR_W-1:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a < ADDR_W'(REG_COUNT)) begin
      v = r[a[4:0]];
    end
    return v;
  endfunction : reg_value

  function automatic logic [ADDR_W-1:0] step_addr(
    input logic [ADDR_W-1:0] a, input logic lsb);
    logic [ADDR_W-1:0] n;
    n = a;
    if (lsb && a < ADDR_W'(REG_COUNT - 1)) begin
      n = a + ADDR_W'(1);
    end else if (!lsb && a != '0) begin
      n = a - ADDR_W'(1);
    end
    return n;
  endfunction : step_addr

  ////////////////////////////////////////////////////////////////////////////
  // Link clock domain

  logic [2:0] lsync;
  logic hw_rst;
  logic en_l;
  logic strap_l;
  logic live;
  dscp_link_t l;
  dscp_link_t next_l;
  dscp_drive_t d;
  dscp_drive_t next_d;

  dscp_sync #(.WIDTH(3)) u_link_sync (
    .clk_i(link.sclk),
    .d_i({reset_i, clk_en_i, strap_mode_i}),
    .q_o(lsync)
  );

  assign hw_rst = lsync[2];
  assign en_l = lsync[1];
  assign strap_l = lsync[0];

  // Cleared while select is high, so the first edge of a segment is seen
  always_ff @(posedge link.sclk or posedge link.port_select_n) begin
    if (link.port_select_n) begin
      live <= 1'b0;
    end else begin
      live <= 1'b1;
    end
  end

  always_comb begin
    logic lsb_v;
    logic wide_v;
    logic restart_v;
    logic [7:0] base_v;
    logic [2:0] cnt_v;
    logic [7:0] byte_v;
    logic [ADDR_W-1:0] a_v;
    lsb_v = l.regs[ADDR_CFG][CFG_LSB_BIT];
    wide_v = l.regs[ADDR_CFG][CFG_WIDE_BIT];
    restart_v = !live && l.bit_cnt != 3'h0;
    base_v = restart_v ? 8'h00 : l.sh;
    cnt_v = restart_v ? 3'h0 : l.bit_cnt;
    byte_v = lsb_v ? {link.sdio, base_v[7:1]} : {base_v[6:0], link.sdio};
    a_v = l.addr;
    next_l = l;
    if (hw_rst) begin
      next_l.phase = DP_INS0;
      next_l.bit_cnt = 3'h0;
      next_l.rd = 1'b0;
      for (int r = 0; r < REG_COUNT; r++) begin
        next_l.regs[r] = REG_RESET;
      end
      next_l.regs[ADDR_CFG] = CFG_RESET;
    end else if (en_l && !strap_l && !link.port_select_n) begin
      if (restart_v) begin
        next_l.phase = DP_INS0;
      end
      next_l.sh = byte_v;
      next_l.bit_cnt = cnt_v + 3'h1;
      if (l.phase == DP_DATA && l.rd && !restart_v) begin
        next_l.out_sh = lsb_v ? {1'b0, l.out_sh[7:1]} :
                                {l.out_sh[6:0], 1'b0};
      end
      if (cnt_v == LAST_BIT) begin
        case (next_l.phase)
          DP_INS0: begin
            next_l.rd = byte_v[INS_RD_BIT];
            next_l.left = byte_v[INS_COUNT_HI:INS_COUNT_LO];
            next_l.addr = {8'h00, byte_v[4:0]};
            if (wide_v) begin
              next_l.phase = DP_INS1;
            end else begin
              next_l.phase = DP_DATA;
              next_l.out_sh = reg_value(l.regs, next_l.addr);
            end
          end
          DP_INS1: begin
            next_l.addr = {l.addr[4:0], byte_v};
            next_l.phase = DP_DATA;
            next_l.out_sh = reg_value(l.regs, next_l.addr);
          end
          DP_DATA: begin
            if (!l.rd && a_v < ADDR_W'(REG_COUNT)) begin
              next_l.regs[a_v[4:0]] = (a_v == ADDR_W'(ADDR_CFG)) ?
                (byte_v & CFG_MASK) : byte_v;
            end
            // New bit order takes effect for the rest of the cycle
            next_l.addr = step_addr(a_v,
              next_l.regs[ADDR_CFG][CFG_LSB_BIT]);
            next_l.out_sh = reg_value(next_l.regs, next_l.addr);
            if (l.left == 2'h0) begin
              next_l.phase = DP_INS0;
            end else begin
              next_l.left = l.left - 2'h1;
            end
          end
          default: begin
            next_l.phase = DP_INS0;
          end
        endcase
      end
      if (next_l.regs[ADDR_CFG][CFG_SRST_BIT]) begin
        for (int r = 0; r < REG_COUNT; r++) begin
          if (r != ADDR_CFG && r != ADDR_KEEP) begin
            next_l.regs[r] = REG_RESET;
          end
        end
      end
    end
  end

  always_ff @(posedge link.sclk) begin
    l <= next_l;
  end

  always_comb begin
    next_d = d;
    if (hw_rst) begin
      next_d = '0;
    end else if (en_l) begin
      next_d.drv = live && !strap_l && l.rd && l.phase == DP_DATA;
      next_d.dout = l.regs[ADDR_CFG][CFG_LSB_BIT] ?
                    l.out_sh[0] : l.out_sh[7];
    end
  end

  // Launch on the falling edge gives the first read bit a full period
  always_ff @(negedge link.sclk) begin
    d <= next_d;
  end

  assign link.sdio_dev_o = d.dout;
  assign link.sdio_dev_oe = d.drv && !link.port_select_n &&
    l.regs[ADDR_CFG][CFG_DIR_BIT];
  assign link.serial_data_out_o = d.dout;
  assign link.serial_data_out_oe = d.drv && !link.port_select_n &&
    !l.regs[ADDR_CFG][CFG_DIR_BIT];
  assign regs_o = l.regs;

  ////////////////////////////////////////////////////////////////////////////
  // Reference clock domain: strap controls

  logic [6:0] rs;
  dscp_strap_t s;
  dscp_strap_t next_s;

  dscp_sync #(.WIDTH(7)) u_pin_sync (
    .clk_i(ref_clk_i),
    .d_i({strap_mode_i, link.port_select_n, link.sclk, link.sdio,
          link.serial_data_out, strap_unsigned_i, power_down_in_i}),
    .q_o(rs)
  );

  always_comb begin
    next_s = s;
    if (reset_i) begin
      next_s = '0;
    end else if (clk_en_i) begin
      next_s = '0;
      if (rs[6]) begin
        next_s.interp_2x = rs[5];
        next_s.fs_lo = rs[4];
        next_s.buf_en = rs[3];
        next_s.fs_hi = rs[2];
        next_s.dac_unsigned = rs[1];
        next_s.pd = rs[0];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    s <= next_s;
  end

  assign dac_unsigned_o = s.dac_unsigned;
  assign interp_2x_o = s.interp_2x;
  assign fullscale_sel_hi_o = s.fs_hi;
  assign fullscale_sel_lo_o = s.fs_lo;
  assign power_down_o = s.pd;
  assign input_buffer_en_o = s.buf_en;

endmodule : dscp_device

// ==== rtl/dscp_pkg.sv ====
// Purpose: Shared constants and types of the serial configuration port
// Assumes: Host makes the serial clock from a 25 MHz reference
// Notes: Register contents beyond the port configuration are plain storage
package dscp_pkg;

  localparam int REG_COUNT = 32;
  localparam int ADDR_CFG = 0;
  localparam int ADDR_KEEP = 4;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] CFG_MASK = 8'hF0;
  localparam int CFG_DIR_BIT = 7;
  localparam int CFG_LSB_BIT = 6;
  localparam int CFG_SRST_BIT = 5;
  localparam int CFG_WIDE_BIT = 4;
  localparam int INS_RD_BIT = 7;
  localparam int INS_COUNT_HI = 6;
  localparam int INS_COUNT_LO = 5;
  localparam int ADDR_W = 13;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam int MAX_BITS = 40;
  localparam int RECOVER_PART_BITS = 4;
  localparam int RECOVER_BITS = 24;

  // Serial clock limit and the half period the host uses
  localparam int REF_HZ = 25_000_000;
  localparam int SCLK_MAX_HZ = 20_000_000;
  localparam int SCLK_MIN_HALF_CYC =
    (REF_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
  // Wider than the minimum so read data survives the input synchroniser
  localparam int SCLK_HALF_CYC = (SCLK_MIN_HALF_CYC > 4) ?
    SCLK_MIN_HALF_CYC : 4;

  typedef enum logic [1:0] {DP_INS0, DP_INS1, DP_DATA} dscp_phase_t;

  function automatic logic [7:0] dscp_order(input logic [7:0] b,
                                            input logic lsb);
    logic [7:0] r;
    r = b;
    if (lsb) begin
      for (int i = 0; i < 8; i++) begin
        r[i] = b[7 - i];
      end
    end
    return r;
  endfunction : dscp_order

endpackage : dscp_pkg

// ==== rtl/dscp_if.sv ====
// Purpose: Pins of the serial configuration link between host and device
// Assumes: Each party drives only through its own output and enable
// Notes: Undriven sdio resolves low, undriven serial_data_out follows sdo_ext, which the bench drives
`timescale 1ns/100ps
interface dscp_if;
  logic sclk;
  logic port_select_n;
  logic sdio_host_o;
  logic sdio_host_oe;
  logic sdio_dev_o;
  logic sdio_dev_oe;
  logic serial_data_out_o;
  logic serial_data_out_oe;
  logic sdo_ext;
  logic sdio;
  logic serial_data_out;

  assign sdio = sdio_dev_oe ? sdio_dev_o :
                (sdio_host_oe ? sdio_host_o : 1'b0);
  assign serial_data_out = serial_data_out_oe ? serial_data_out_o : sdo_ext;

  modport dev(input sclk, input port_select_n, input sdio,
              input serial_data_out, output sdio_dev_o, output sdio_dev_oe,
              output serial_data_out_o, output serial_data_out_oe);
  modport host(output sclk, output port_select_n, output sdio_host_o,
               output sdio_host_oe, input sdio, input serial_data_out);
endinterface : dscp_if

// ==== rtl/dscp_sync.sv ====
// Purpose: Two-stage synchroniser for independent level signals
// Assumes: Each bit is a level that may be sampled apart from the others
// Notes: First stage feeds only the second stage
`timescale 1ns/100ps
module dscp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_i) begin
    meta <= d_i;
    q_o <= meta;
  end
endmodule : dscp_sync

// ==== rtl/dscp_host.sv ====
// Purpose: Host end that runs serial cycles for a command port
// Assumes: Device starts from reset in MSB-first, short, four-wire mode
// Notes: Tracks the device configuration from its own writes to address 0
`timescale 1ns/100ps
module dscp_host
  import dscp_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic cmd_read_i,
  input wire logic cmd_recover_i,
  input wire logic [1:0] cmd_count_i,
  input wire logic [4:0] cmd_addr_i,
  input wire logic [31:0] cmd_wdata_i,
  output logic rsp_valid_o,
  output logic [31:0] rsp_rdata_o,
  dscp_if.host link
);

  typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_GAP} dscp_hstate_t;

  typedef struct packed {
    dscp_hstate_t st;
    logic [3:0] half;
    logic [5:0] idx;
    logic [5:0] nbits;
    logic [MAX_BITS-1:0] tx;
    logic [31:0] rx;
    logic rd;
    logic [1:0] cnt;
    logic sel_n;
    logic sclk;
    logic oe;
    logic recover;
    logic srst_pend;
    logic [7:0] cfg;
    logic rsp_valid;
    logic [31:0] rdata;
  } dscp_host_t;

  dscp_host_t h;
  dscp_host_t next_h;
  logic [1:0] rsy;

  dscp_sync #(.WIDTH(2)) u_rx_sync (
    .clk_i(ref_clk_i),
    .d_i({link.sdio, link.serial_data_out}),
    .q_o(rsy)
  );

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    logic lsb_v;
    logic [7:0] b0_v;
    logic [7:0] raw_v;
    lsb_v = h.cfg[CFG_LSB_BIT];
    b0_v = cmd_wdata_i[7:0];
    raw_v = 8'h00;
    next_h = h;
    next_h.rsp_valid = 1'b0;
    if (reset_i) begin
      next_h = '0;
      next_h.sel_n = 1'b1;
      next_h.cfg = CFG_RESET;
    end else if (clk_en_i) begin
      case (h.st)
        H_IDLE: begin
          if (cmd_valid_i) begin
            next_h.st = H_LOW;
            next_h.half = '0;
            next_h.idx = '0;
            next_h.sel_n = 1'b0;
            next_h.oe = 1'b1;
            next_h.rx = '0;
            next_h.cnt = cmd_count_i;
            if (cmd_recover_i) begin
              next_h.rd = 1'b0;
              next_h.recover = 1'b1;
              next_h.tx = '0;
              // One frame ending mid-byte, so the device restarts cleanly
              next_h.nbits = 6'(RECOVER_PART_BITS + RECOVER_BITS);
            end else begin
              next_h.rd = cmd_read_i;
              if (!cmd_read_i && cmd_addr_i == 5'(ADDR_CFG)) begin
                b0_v[CFG_WIDE_BIT] = 1'b0;
                if (h.srst_pend) begin
                  b0_v[CFG_SRST_BIT] = 1'b0;
                end
                next_h.srst_pend = b0_v[CFG_SRST_BIT];
                next_h.cfg = b0_v & CFG_MASK;
              end
              next_h.tx = {dscp_order({cmd_read_i, cmd_count_i,
                                       cmd_addr_i}, lsb_v),
                           dscp_order(b0_v, lsb_v),
                           dscp_order(cmd_wdata_i[15:8], lsb_v),
                           dscp_order(cmd_wdata_i[23:16], lsb_v),
                           dscp_order(cmd_wdata_i[31:24], lsb_v)};
              next_h.nbits = {cmd_count_i + 3'h2, 3'h0};
            end
          end
        end
        H_LOW: begin
          next_h.half = h.half + 4'h1;
          if (h.half == 4'(SCLK_HALF_CYC - 1)) begin
            next_h.half = '0;
            next_h.sclk = 1'b1;
            next_h.st = H_HIGH;
            if (h.rd && h.idx >= 6'h08) begin
              // Sampled while the clock is still low
              next_h.rx = {h.rx[30:0], h.cfg[CFG_DIR_BIT] ? rsy[1] :
                                                             rsy[0]};
            end
          end
        end
        H_HIGH: begin
          next_h.half = h.half + 4'h1;
          if (h.half == 4'(SCLK_HALF_CYC - 1)) begin
            next_h.half = '0;
            next_h.sclk = 1'b0;
            next_h.idx = h.idx + 6'h01;
            next_h.tx = {h.tx[MAX_BITS-2:0], 1'b0};
            if (h.rd && h.idx == 6'h07) begin
              next_h.oe = 1'b0;
            end
            next_h.st = (h.idx + 6'h01 == h.nbits) ? H_GAP : H_LOW;
          end
        end
        H_GAP: begin
          next_h.half = h.half + 4'h1;
          next_h.oe = 1'b0;
          if (h.half == 4'(SCLK_HALF_CYC - 1)) begin
            next_h.sel_n = 1'b1;
          end
          if (h.half == 4'(2 * SCLK_HALF_CYC - 1)) begin
            next_h.half = '0;
            next_h.st = H_IDLE;
            if (h.recover) begin
              // Zero bytes restore the reset format; no response pulse
              next_h.recover = 1'b0;
              next_h.cfg = CFG_RESET;
              next_h.srst_pend = 1'b0;
            end else begin
              next_h.rsp_valid = 1'b1;
              next_h.rdata = '0;
              for (int k = 0; k < 4; k++) begin
                if (k <= int'(h.cnt)) begin
                  raw_v = h.rx[8 * (int'(h.cnt) - k) +: 8];
                  next_h.rdata[8 * k +: 8] = dscp_order(raw_v, lsb_v);
                end
              end
            end
          end
        end
        default: begin
          next_h.st = H_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    h <= next_h;
  end

  assign cmd_ready_o = h.st == H_IDLE && !reset_i;
  assign rsp_valid_o = h.rsp_valid;
  assign rsp_rdata_o = h.rdata;
  assign link.sclk = h.sclk;
  assign link.port_select_n = h.sel_n;
  assign link.sdio_host_o = h.tx[MAX_BITS-1];
  assign link.sdio_host_oe = h.oe && !h.sel_n;

endmodule : dscp_host

// ==== tb/dscp_assertions.sv ====
// Purpose: Link checks between host and device ends
// Assumes: Sampled on the reference clock; sclk is a host flop
// Notes: warm_i masks the span where device drive flops are unknown
`timescale 1ns/100ps
module dscp_assertions
  import dscp_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic warm_i,
  input wire logic sclk,
  input wire logic port_select_n,
  input wire logic sdio_host_oe,
  input wire logic sdio_dev_o,
  input wire logic sdio_dev_oe,
  input wire logic serial_data_out_oe
);
  typedef struct packed {
    logic sclk_q;
    logic [5:0] rise_cnt;
  } dscp_chk_t;
  dscp_chk_t st;
  dscp_chk_t next_st;
  logic any_oe;
  assign any_oe = sdio_dev_oe | serial_data_out_oe;
  ////////////////////////////////////////////////////////////////////////////
  // Rising serial edges per frame; saturates rather than wrapping
  always_comb begin
    next_st = st;
    next_st.sclk_q = sclk;
    if (reset_i || port_select_n) begin
      next_st.rise_cnt = 6'h00;
    end else if (sclk && !st.sclk_q && st.rise_cnt != 6'h3F) begin
      next_st.rise_cnt = st.rise_cnt + 6'h01;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    st <= next_st;
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i || !warm_i);
  sequence s_sclk_high;
    sclk [*4] ##1 !sclk;
  endsequence
  sequence s_launch;
    $fell(sclk) && !sdio_host_oe;
  endsequence
  property p_idle_float;
    port_select_n |-> !any_oe;
  endproperty
  a_idle_float: assert property (p_idle_float)
    else $error("data pin driven while deselected");
  property p_idle_sclk;
    port_select_n |-> !sclk;
  endproperty
  a_idle_sclk: assert property (p_idle_sclk)
    else $error("serial clock high outside frame");
  property p_sclk_rate;
    $rose(sclk) |-> s_sclk_high;
  endproperty
  a_sclk_rate: assert property (p_sclk_rate)
    else $error("serial clock high phase wrong length");
  property p_launch;
    $rose(any_oe) |-> s_launch;
  endproperty
  a_launch: assert property (p_launch)
    else $error("read drive not started on falling clock");
  property p_bit_hold;
    sdio_dev_oe && $past(sdio_dev_oe) && $changed(sdio_dev_o) |-> $fell(sclk);
  endproperty
  a_bit_hold: assert property (p_bit_hold)
    else $error("read bit changed off falling clock");
  property p_one_driver;
    !(sdio_host_oe && sdio_dev_oe) && !(sdio_dev_oe && serial_data_out_oe);
  endproperty
  a_one_driver: assert property (p_one_driver)
    else $error("two drivers at once");
  property p_instr_len;
    $rose(any_oe) |-> st.rise_cnt == 6'h08;
  endproperty
  a_instr_len: assert property (p_instr_len)
    else $error("read data not after eight instruction bits");
  property p_byte_frame;
    $rose(port_select_n) |->
      st.rise_cnt[2:0] == 3'h0 ||
      st.rise_cnt == 6'(RECOVER_PART_BITS + RECOVER_BITS);
  endproperty
  a_byte_frame: assert property (p_byte_frame)
    else $error("select released off a byte boundary");
endmodule : dscp_assertions

// ==== tb/dscp_tb.sv ====
// Purpose: Self-checking bench joining host and device ends
// Assumes: Device link reset needs live serial clock, so resets are split
// Notes: Register model mirrors address stepping and soft reset
`timescale 1ns/100ps
module dscp_tb;
  import dscp_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_host = 1'b1;
  logic rst_dev = 1'b1;
  logic warm = 1'b0;
  logic strap_mode = 1'b0;
  logic strap_uns = 1'b0;
  logic strap_pd = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic cmd_recover = 1'b0;
  logic [1:0] cmd_count = 2'h0;
  logic [4:0] cmd_addr = 5'h00;
  logic [31:0] cmd_wdata = 32'h0000_0000;
  logic cmd_ready;
  logic rsp_valid;
  logic [31:0] rsp_rdata;
  logic [REG_COUNT-1:0][7:0] regs;
  logic [5:0] pins;
  logic [7:0] mem [REG_COUNT];
  int n_fail = 0;
  int total_checks = 0;
  dscp_if link_if();
  always #20 ref_clk_i = ~ref_clk_i;
  // Undriven output pin wanders, so stale read data cannot pass
  initial link_if.sdo_ext = 1'b0;
  always @(negedge ref_clk_i) begin
    if (!strap_mode) begin
      link_if.sdo_ext <= 1'($urandom_range(1, 0));
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  dscp_host dscp_host_inst (
    .ref_clk_i(ref_clk_i), .reset_i(rst_host), .clk_en_i(1'b1),
    .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready),
    .cmd_read_i(cmd_read), .cmd_recover_i(cmd_recover),
    .cmd_count_i(cmd_count), .cmd_addr_i(cmd_addr),
    .cmd_wdata_i(cmd_wdata), .rsp_valid_o(rsp_valid),
    .rsp_rdata_o(rsp_rdata), .link(link_if.host));
  dscp_device dscp_device_inst (
    .ref_clk_i(ref_clk_i), .reset_i(rst_dev), .clk_en_i(1'b1),
    .strap_mode_i(strap_mode), .strap_unsigned_i(strap_uns),
    .power_down_in_i(strap_pd), .link(link_if.dev), .regs_o(regs),
    .dac_unsigned_o(pins[5]), .interp_2x_o(pins[4]),
    .fullscale_sel_hi_o(pins[3]), .fullscale_sel_lo_o(pins[2]),
    .power_down_o(pins[1]), .input_buffer_en_o(pins[0]));
  dscp_assertions dscp_assertions_inst (
    .ref_clk_i(ref_clk_i), .reset_i(rst_dev), .warm_i(warm),
    .sclk(link_if.sclk), .port_select_n(link_if.port_select_n),
    .sdio_host_oe(link_if.sdio_host_oe), .sdio_dev_o(link_if.sdio_dev_o),
    .sdio_dev_oe(link_if.sdio_dev_oe),
    .serial_data_out_oe(link_if.serial_data_out_oe));
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    if (n_fail == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t reg %h exp %h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t read %h exp %h", $time, got, exp);
    end
  endtask : chk_rd
  task automatic chk_pin(input logic [5:0] got, input logic [5:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t pins %b exp %b", $time, got, exp);
    end
  endtask : chk_pin
  // One command; model follows config bits as each byte lands
  task automatic run(input logic rd, input logic rc, input int cnt,
                     input int adr, input logic [31:0] wd);
    int n;
    int a;
    logic [31:0] exp;
    @(negedge ref_clk_i);
    cmd_valid = 1'b1;
    cmd_read = rd;
    cmd_recover = rc;
    cmd_count = 2'(cnt);
    cmd_addr = 5'(adr);
    cmd_wdata = wd;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 1000) begin
      @(negedge ref_clk_i);
      n++;
    end
    @(negedge ref_clk_i);
    cmd_valid = 1'b0;
    while ((rc ? cmd_ready : rsp_valid) !== 1'b1 && n < 1000) begin
      @(negedge ref_clk_i);
      n++;
    end
    if (n >= 1000) begin
      n_fail++;
      $display("CHECK FAILED t=%0t command hung", $time);
      test_done();
    end
    a = adr;
    exp = 32'h0000_0000;
    for (int k = 0; k <= cnt && !strap_mode; k++) begin
      if (rd) begin
        exp[8*k +: 8] = mem[a];
      end else if (a == ADDR_CFG) begin
        mem[a] = wd[8*k +: 8] & CFG_MASK & 8'hEF;
      end else begin
        mem[a] = wd[8*k +: 8];
      end
      if (mem[ADDR_CFG][CFG_LSB_BIT]) begin
        a = (a < 31) ? a + 1 : a;
      end else begin
        a = (a > 0) ? a - 1 : a;
      end
    end
    if (mem[ADDR_CFG][CFG_SRST_BIT]) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        if (i != ADDR_CFG && i != ADDR_KEEP) mem[i] = 8'h00;
      end
    end
    if (rd) chk_rd(rsp_rdata, exp);
    for (int i = 0; i < REG_COUNT; i++) chk_reg(regs[i], mem[i]);
  endtask : run
  task automatic hw_reset();
    warm = 1'b0;
    rst_host = 1'b1;
    rst_dev = 1'b1;
    foreach (mem[i]) mem[i] = 8'h00;
    repeat (20) @(negedge ref_clk_i);
    rst_host = 1'b0;
    run(1'b0, 1'b1, 0, 0, 32'h0000_0000);
    rst_dev = 1'b0;
    run(1'b0, 1'b1, 0, 0, 32'h0000_0000);
    warm = 1'b1;
  endtask : hw_reset
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int adr;
    void'($urandom(32'h57e7));
    hw_reset();
    for (int m = 0; m < 2; m++) begin
      // Wide bit and low nibble offered too; both must be dropped
      run(1'b0, 1'b0, 0, 0, m ? 32'h0000_005F : 32'h0000_0000);
      for (int c = 0; c < 4; c++) begin
        adr = m ? $urandom_range(31 - c, 1) : $urandom_range(31, c + 1);
        run(1'b0, 1'b0, c, adr, $urandom());
        run(1'b1, 1'b0, c, adr, 32'h0000_0000);
      end
      run(1'b1, 1'b0, 3, m ? 30 : 1, 32'h0000_0000);
    end
    run(1'b0, 1'b0, 0, 0, 32'h0000_00C0);
    run(1'b1, 1'b0, 1, 2, 32'h0000_0000);
    run(1'b0, 1'b1, 0, 0, 32'h0000_0000);
    run(1'b0, 1'b0, 0, ADDR_KEEP, $urandom());
    run(1'b0, 1'b0, 0, 0, 32'h0000_0020);
    run(1'b0, 1'b0, 0, 0, 32'h0000_0000);
    run(1'b1, 1'b0, 3, 7, 32'h0000_0000);
    strap_mode = 1'b1;
    strap_uns = 1'($urandom_range(1, 0));
    strap_pd = 1'($urandom_range(1, 0));
    @(negedge ref_clk_i);
    link_if.sdo_ext = 1'($urandom_range(1, 0));
    // Strap outputs pass a synchroniser; allow it to settle
    repeat (8) @(negedge ref_clk_i);
    chk_pin(pins, {strap_uns, 1'b1, link_if.sdo_ext, 1'b0, strap_pd,
                   1'b0});
    run(1'b0, 1'b0, 0, 5, 32'h0000_00A5);
    strap_mode = 1'b0;
    repeat (8) @(negedge ref_clk_i);
    chk_pin(pins, 6'h00);
    hw_reset();
    run(1'b1, 1'b0, 3, 7, 32'h0000_0000);
    test_done();
  end
endmodule : dscp_tb
